// ---- sdmc_core.sv ----
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - each rising step edge moves the position one microstep, up or down by the direction line sampled at that edge
// - step size per edge comes from the resolution select sampled at that edge, not the held copy
// - direction and resolution are latched at each rising step edge; the latched copies steer nothing and only feed status
// - controller changes act at the first step edge after them, no extra strobe
// - enable high drives the output stage; enable low turns it off
// - position keeps counting on step edges while enable holds outputs off
// - enable acts at any moment, independent of step and other inputs
// - reset low turns outputs off and returns position to phase a zero, b full
// - reset low also clears a latched fault once its cause is gone
// - fault output pulls low while a fault is latched
// - phase short, phase to ground short or overcurrent raise a fault
// - a raised fault turns outputs off and holds until reset low
// - over-temperature turns outputs off without latching or fault output
// - full-step output is low while the position stands on a full step
// - full step is a phase a or b zero crossing, same for every resolution
// - full-step output follows the commanded position only
// - undriven inputs read high, so drive stays enabled and out of reset
// - top select bit gives binary 2..256, clear gives decimal 5..250, two codes invalid
module sdmc_core (
  input  wire logic                        clock,
  input  wire logic                        srst,
  input  wire logic                        step_pulse,
  input  wire logic                        direction,
  input  wire logic                        enable,
  input  wire logic                        motor_reset_n,
  input  wire logic [3:0]                  microstep_resolution_select,
  input  wire logic                        short_phase_to_phase,
  input  wire logic                        short_phase_to_ground,
  input  wire logic                        overcurrent,
  input  wire logic                        over_temperature,
  input  wire logic [sdmc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [sdmc_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_write,
  input  wire logic                        reg_read,
  output logic      [sdmc_pkg::DATA_W-1:0] reg_rdata,
  output logic      [7:0]                  phase_a_amp,
  output logic                             phase_a_neg,
  output logic      [7:0]                  phase_b_amp,
  output logic                             phase_b_neg,
  output logic                             bridge_enable,
  input  wire logic                        fault_pin_in,
  output logic                             fault_pin_out,
  output logic                             fault_pin_oe,
  input  wire logic                        fullstep_pin_in,
  output logic                             fullstep_pin_out,
  output logic                             fullstep_pin_oe
);
  import sdmc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                held_dir_ff;
  logic [3:0]          held_res_ff;
  logic [14:0]         frac_ff;
  logic [1:0]          quad_ff;
  logic                neg_a_ff;
  logic                neg_b_ff;
  logic                fault_ff;
  logic                bridge_ff;
  logic                fstep_ff;
  logic [DATA_W-1:0]   ctrl_ff;
  logic [DATA_W-1:0]   rdata_ff;

  logic                step_rise;
  logic [14:0]         step_size_w;
  logic [15:0]         frac_up_sum;
  logic                up_carry;
  logic                down_borrow;
  logic [14:0]         nxt_frac;
  logic [1:0]          nxt_quad;
  logic                fault_cause;
  logic                nxt_fault;
  logic                nxt_bridge;
  logic                at_fullstep;
  logic                res_invalid;
  logic [15:0]         arg_rise;
  logic [15:0]         arg_fall;
  logic [15:0]         arg_a;
  logic [15:0]         arg_b;
  logic [DATA_W-1:0]   status_w;
  logic [DATA_W-1:0]   position_w;
  logic [DATA_W-1:0]   nxt_rdata;

  // ----------------------------------------------------------------
  // step edge
  // ----------------------------------------------------------------
  sdmc_step_edge u_step_edge (
    .clock   (clock),
    .srst    (srst),
    .step_in (step_pulse),
    .rise    (step_rise)
  );

  // ----------------------------------------------------------------
  // position generator
  // ----------------------------------------------------------------
  // size taken from the select sampled at this very edge
  assign step_size_w = sdmc_step_size(microstep_resolution_select);
  assign frac_up_sum = {1'b0, frac_ff} + {1'b0, step_size_w};
  assign up_carry    = frac_up_sum >= {1'b0, FULL_STEP_SPAN};
  assign down_borrow = frac_ff < step_size_w;

  // next position, wrapping through the quadrants
  assign nxt_frac = direction ?
                    (up_carry ? 15'(frac_up_sum - {1'b0, FULL_STEP_SPAN}) : frac_up_sum[14:0]) :
                    (down_borrow ? 15'(frac_ff + FULL_STEP_SPAN - step_size_w) : 15'(frac_ff - step_size_w));
  assign nxt_quad = direction ?
                    (up_carry ? 2'(quad_ff + 2'h1) : quad_ff) :
                    (down_borrow ? 2'(quad_ff - 2'h1) : quad_ff);

  // latch and move on each edge; enable plays no part here
  always_ff @(posedge clock) begin
    if (srst || !motor_reset_n) begin
      frac_ff <= FRAC_INIT;
      quad_ff <= QUAD_INIT;
    end else if (step_rise) begin
      frac_ff <= nxt_frac;
      quad_ff <= nxt_quad;
    end
  end

  // held direction and resolution, visible in status
  always_ff @(posedge clock) begin
    if (srst) begin
      held_dir_ff <= 1'b1;
      held_res_ff <= 4'hf;
    end else if (step_rise) begin
      held_dir_ff <= direction;
      held_res_ff <= microstep_resolution_select;
    end
  end

  assign res_invalid = sdmc_step_size(held_res_ff) == 15'h0000;

  // ----------------------------------------------------------------
  // phase currents
  // ----------------------------------------------------------------
  // rising magnitude in quadrants 0 and 2, falling in 1 and 3
  assign arg_rise = {1'b0, frac_ff};
  assign arg_fall = {1'b0, FULL_STEP_SPAN} - {1'b0, frac_ff};
  // argument picked per phase so the amplitudes leave the shaper flops
  assign arg_a    = quad_ff[0] ? arg_fall : arg_rise;
  assign arg_b    = quad_ff[0] ? arg_rise : arg_fall;

  sdmc_sine_shaper u_shape_a (
    .clock  (clock),
    .srst   (srst),
    .arg    (arg_a),
    .amp_ff (phase_a_amp)
  );

  sdmc_sine_shaper u_shape_b (
    .clock  (clock),
    .srst   (srst),
    .arg    (arg_b),
    .amp_ff (phase_b_amp)
  );

  // signs registered in step with the shaper delay
  always_ff @(posedge clock) begin
    if (srst) begin
      neg_a_ff <= 1'b0;
      neg_b_ff <= 1'b0;
    end else begin
      neg_a_ff <= quad_ff[1];
      neg_b_ff <= quad_ff[1] ^ quad_ff[0];
    end
  end

  assign phase_a_neg = neg_a_ff;
  assign phase_b_neg = neg_b_ff;

  // ----------------------------------------------------------------
  // fault, over-temperature and output stage gating
  // ----------------------------------------------------------------
  assign fault_cause = short_phase_to_phase | short_phase_to_ground | overcurrent;
  // a live cause wins over the reset clear
  assign nxt_fault   = fault_cause | (fault_ff & motor_reset_n);
  // enable high or undriven runs the stage; it is looked at every cycle
  assign nxt_bridge  = enable & motor_reset_n & ~fault_cause & ~fault_ff & ~over_temperature
                       & ctrl_ff[CTRL_RUN_BIT];

  always_ff @(posedge clock) begin
    if (srst) begin
      fault_ff  <= 1'b0;
      bridge_ff <= 1'b0;
    end else begin
      fault_ff  <= nxt_fault;
      bridge_ff <= nxt_bridge;
    end
  end

  assign bridge_enable = bridge_ff;
  assign fault_pin_out = 1'b0;
  assign fault_pin_oe  = fault_ff;

  // ----------------------------------------------------------------
  // full-step output from the commanded position
  // ----------------------------------------------------------------
  assign at_fullstep = frac_ff == FRAC_INIT;

  always_ff @(posedge clock) begin
    if (srst) begin
      fstep_ff <= 1'b0;
    end else begin
      fstep_ff <= at_fullstep;
    end
  end

  assign fullstep_pin_out = 1'b0;
  assign fullstep_pin_oe  = fstep_ff;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  assign status_w = {20'h0_0000, held_res_ff, res_invalid, fullstep_pin_in, fault_pin_in,
                     fstep_ff, held_dir_ff, bridge_ff, over_temperature, fault_ff};
  assign position_w = {14'h0000, quad_ff, 1'b0, frac_ff};
  assign nxt_rdata = !reg_read                   ? 32'h0000_0000 :
                     (reg_addr == ADDR_CTRL)     ? ctrl_ff :
                     (reg_addr == ADDR_STATUS)   ? status_w :
                     (reg_addr == ADDR_POSITION) ? position_w : 32'h0000_0000;

  // control write and registered read data
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_ff  <= CTRL_RESET;
      rdata_ff <= 32'h0000_0000;
    end else begin
      if (reg_write && reg_addr == ADDR_CTRL) begin
        ctrl_ff <= {31'h0000_0000, reg_wdata[CTRL_RUN_BIT]};
      end
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  chk_step_moves: assert property (
    step_rise && motor_reset_n && step_size_w != 15'h0000 |=> {quad_ff, frac_ff} != $past({quad_ff, frac_ff}))
    else $error("step edge did not move the position");

  chk_step_size: assert property (
    step_rise && motor_reset_n && direction && !up_carry |=> frac_ff == $past(frac_up_sum[14:0]))
    else $error("position did not advance by the selected size");

  chk_hold_latch: assert property (
    !step_rise |=> held_dir_ff == $past(held_dir_ff) && held_res_ff == $past(held_res_ff))
    else $error("held direction or resolution changed without a step edge");

  chk_enable_off: assert property (
    !enable |=> !bridge_enable)
    else $error("output stage on while enable low");

  chk_disabled_count: assert property (
    step_rise && !enable && motor_reset_n && step_size_w != 15'h0000
    |=> {quad_ff, frac_ff} != $past({quad_ff, frac_ff}) && !bridge_enable)
    else $error("position froze while outputs disabled");

  chk_reset_home: assert property (
    !motor_reset_n |=> frac_ff == FRAC_INIT && quad_ff == QUAD_INIT && !bridge_enable
                       ##2 phase_a_amp == 8'h00 || !motor_reset_n)
    else $error("reset did not return to the initial position");

  chk_fault_raise: assert property (
    fault_cause |=> fault_pin_oe && !bridge_enable)
    else $error("fault cause did not latch a fault");

  chk_fault_hold: assert property (
    fault_ff && motor_reset_n |=> fault_pin_oe ##0 !bridge_enable)
    else $error("latched fault released without reset");

  chk_overtemp: assert property (
    over_temperature && !fault_cause && !fault_ff |=> !bridge_enable && !fault_pin_oe)
    else $error("over-temperature handled wrongly");

  chk_fullstep_pin: assert property (
    frac_ff == FRAC_INIT |=> fullstep_pin_oe)
    else $error("full-step output not low on a full step");

  chk_wrap_down: assert property (
    step_rise && motor_reset_n && !direction && quad_ff == QUAD_INIT && down_borrow && step_size_w != 15'h0000
    |=> quad_ff == QUAD_LAST)
    else $error("position did not wrap downward");

  cov_wrap_up:     cover property (step_rise && direction && quad_ff == QUAD_LAST && up_carry);
  cov_fault:       cover property (fault_cause ##1 fault_ff ##[1:20] !fault_ff);
  cov_overtemp:    cover property (bridge_enable ##1 over_temperature ##1 !bridge_enable);
  cov_dis_step:    cover property (!enable && step_rise);

endmodule : sdmc_core
`default_nettype wire

// ---- sdmc_ctrl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module sdmc_ctrl_model (
  input  wire logic       clock,
  output logic            step_pulse,
  output logic            direction,
  output logic            enable,
  output logic            motor_reset_n,
  output logic [3:0]      res_sel
);
  // ------------------------------------------
  // idle levels: lines float high, step low
  // ------------------------------------------
  initial begin
    step_pulse    = 1'b0;
    direction     = 1'b1;
    enable        = 1'b1;
    motor_reset_n = 1'b1;
    res_sel       = 4'hf;
  end

  // change direction and resolution without a step
  task set_lines(input logic dir, input logic [3:0] sel);
    @(posedge clock);
    direction <= dir;
    res_sel   <= sel;
  endtask : set_lines

  // one step, lines set a cycle ahead of the rising edge
  task step(input logic dir, input logic [3:0] sel);
    set_lines(dir, sel);
    @(posedge clock);
    step_pulse <= 1'b1;
    @(posedge clock);
    step_pulse <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : step

  // enable and reset change at any moment, held at least two cycles
  task levels(input logic en, input logic rst_n);
    @(posedge clock);
    enable        <= en;
    motor_reset_n <= rst_n;
    repeat (2) @(posedge clock);
  endtask : levels
endmodule : sdmc_ctrl_model
`default_nettype wire

// ---- sdmc_pkg.sv ----
`default_nettype none
package sdmc_pkg;

  // ----------------------------------------------------------------
  // clock and position generator geometry
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam logic [14:0] FULL_STEP_SPAN  = 15'h7d00;   // counts per full step
  localparam logic [14:0] FRAC_INIT       = 15'h0000;   // phase a at zero
  localparam logic [1:0]  QUAD_INIT       = 2'h0;       // phase b at full current
  localparam logic [1:0]  QUAD_LAST       = 2'h3;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 32;
  localparam logic [3:0]  ADDR_CTRL       = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h4;
  localparam logic [3:0]  ADDR_POSITION   = 4'h8;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
  localparam int          CTRL_RUN_BIT    = 0;
  localparam int          ST_FAULT        = 0;
  localparam int          ST_OVERTEMP     = 1;
  localparam int          ST_DRIVE_ON     = 2;
  localparam int          ST_DIR          = 3;
  localparam int          ST_FULLSTEP     = 4;
  localparam int          ST_FAULT_PIN    = 5;
  localparam int          ST_FSTEP_PIN    = 6;
  localparam int          ST_INVALID      = 7;
  localparam int          ST_RES_LSB      = 8;
  localparam int          POS_QUAD_LSB    = 16;

  // ----------------------------------------------------------------
  // amplitude shaper scaling
  // ----------------------------------------------------------------
  localparam logic [13:0] SCALE_MUL       = 14'h20c5;   // about 2^20 / 125
  localparam int          SCALE_SHIFT     = 20;
  localparam logic [7:0]  AMP_MAX         = 8'hff;

  // counts added per step for each resolution code, zero when invalid
  function automatic logic [14:0] sdmc_step_size(input logic [3:0] sel);
    logic [14:0] size;
    size = 15'h0000;
    unique case (sel)
      4'hf: size = 15'h3e80;   // 2
      4'he: size = 15'h1f40;   // 4
      4'hd: size = 15'h0fa0;   // 8
      4'hc: size = 15'h07d0;   // 16
      4'hb: size = 15'h03e8;   // 32
      4'ha: size = 15'h01f4;   // 64
      4'h9: size = 15'h00fa;   // 128
      4'h8: size = 15'h007d;   // 256
      4'h7: size = 15'h1900;   // 5
      4'h6: size = 15'h0c80;   // 10
      4'h5: size = 15'h0500;   // 25
      4'h4: size = 15'h0280;   // 50
      4'h3: size = 15'h0100;   // 125
      4'h2: size = 15'h0080;   // 250
      4'h1: size = 15'h0000;   // invalid
      4'h0: size = 15'h0000;   // invalid
    endcase
    return size;
  endfunction : sdmc_step_size

endpackage : sdmc_pkg
`default_nettype wire

// ---- sdmc_sine_shaper.sv ----
`timescale 1ns/10ps
`default_nettype none
module sdmc_sine_shaper (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [15:0] arg,
  output logic      [7:0]  amp_ff
);
  import sdmc_pkg::*;

  logic [29:0] scaled;
  logic [8:0]  t;
  logic [26:0] cube;
  logic [10:0] lin3;
  logic [9:0]  y;
  logic [7:0]  nxt_amp;

  // quarter-wave sine by 1.5x - 0.5x^3, x = arg / span in 1/256 units
  assign scaled  = {14'h0000, arg} * {16'h0000, SCALE_MUL};
  assign t       = scaled[SCALE_SHIFT+8:SCALE_SHIFT];
  assign cube    = {18'h0_0000, t} * {18'h0_0000, t} * {18'h0_0000, t};
  assign lin3    = {2'b00, t} + {1'b0, t, 1'b0};
  assign y       = lin3[10:1] - cube[26:17];
  assign nxt_amp = (y > {2'b00, AMP_MAX}) ? AMP_MAX : y[7:0];

  // registered magnitude
  always_ff @(posedge clock) begin
    if (srst) begin
      amp_ff <= 8'h00;
    end else begin
      amp_ff <= nxt_amp;
    end
  end

endmodule : sdmc_sine_shaper
`default_nettype wire

// ---- sdmc_step_edge.sv ----
`timescale 1ns/10ps
`default_nettype none
module sdmc_step_edge (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic step_in,
  output logic      rise
);
  import sdmc_pkg::*;

  logic step_prev_ff;

  // previous level; reset high so a held step gives no false edge
  always_ff @(posedge clock) begin
    if (srst) begin
      step_prev_ff <= 1'b1;
    end else begin
      step_prev_ff <= step_in;
    end
  end

  // one-cycle pulse on each rising edge
  assign rise = step_in & ~step_prev_ff;

endmodule : sdmc_step_edge
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sdmc_pkg::*;
  // ----------------------------------------
  // signals and wiring
  // ----------------------------------------
  logic            clock            = 1'b0;
  logic            srst             = 1'b1;
  logic [2:0]      cause            = 3'h0;
  logic            over_temperature = 1'b0;
  logic [3:0]      reg_addr         = 4'h0;
  logic [31:0]     reg_wdata        = 32'h0000_0000;
  logic            reg_write        = 1'b0;
  logic            reg_read         = 1'b0;
  logic [31:0]     reg_rdata;
  logic [31:0]     rd;
  logic [7:0]      phase_a_amp;
  logic [7:0]      phase_b_amp;
  logic            phase_a_neg;
  logic            phase_b_neg;
  logic            bridge_enable;
  logic            fault_pin_out;
  logic            fault_pin_oe;
  logic            fullstep_pin_out;
  logic            fullstep_pin_oe;
  wire logic       step_pulse;
  wire logic       direction;
  wire logic       enable;
  wire logic       motor_reset_n;
  wire logic [3:0] res_sel;
  // open-drain lines with pull-ups
  wire logic       fault_line    = fault_pin_oe ? fault_pin_out : 1'b1;
  wire logic       fullstep_line = fullstep_pin_oe ? fullstep_pin_out : 1'b1;
  int              fail_count      = 0;
  int              samples_checked = 0;
  int              pos             = 0;
  int              sz;

  // clock generator
  always #25 clock = ~clock;

  sdmc_ctrl_model ctl (.clock(clock), .step_pulse(step_pulse), .direction(direction), .enable(enable),
                       .motor_reset_n(motor_reset_n), .res_sel(res_sel));

  sdmc_core uut (.clock(clock), .srst(srst), .step_pulse(step_pulse), .direction(direction),
                 .enable(enable), .motor_reset_n(motor_reset_n), .microstep_resolution_select(res_sel),
                 .short_phase_to_phase(cause[0]), .short_phase_to_ground(cause[1]),
                 .overcurrent(cause[2]), .over_temperature(over_temperature), .reg_addr(reg_addr),
                 .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
                 .reg_rdata(reg_rdata), .phase_a_amp(phase_a_amp), .phase_a_neg(phase_a_neg),
                 .phase_b_amp(phase_b_amp), .phase_b_neg(phase_b_neg), .bridge_enable(bridge_enable),
                 .fault_pin_in(fault_line), .fault_pin_out(fault_pin_out), .fault_pin_oe(fault_pin_oe),
                 .fullstep_pin_in(fullstep_line), .fullstep_pin_out(fullstep_pin_out),
                 .fullstep_pin_oe(fullstep_pin_oe));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : reg_wr

  // read data stand only in the cycle after the strobe
  task reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask : reg_rd

  task settle();
    repeat (3) @(posedge clock);
    @(negedge clock);
  endtask : settle

  // counts per step: 32000 per full step over microsteps
  function automatic int step_counts(input logic [3:0] s);
    int ms[16] = '{0, 0, 250, 125, 50, 25, 10, 5, 256, 128, 64, 32, 16, 8, 4, 2};
    return (ms[s] == 0) ? 0 : 32000 / ms[s];
  endfunction : step_counts

  task do_step(input logic dir, input logic [3:0] s);
    ctl.step(dir, s);
    sz  = step_counts(s);
    pos = dir ? (pos + sz) % 128000 : (pos + 128000 - sz) % 128000;
  endtask : do_step

  task check_pos();
    reg_rd(ADDR_POSITION, rd);
    check(rd & 32'h0003_7fff, ((pos / 32000) << 16) | (pos % 32000));
  endtask : check_pos

  task finish_test();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // watchdog well beyond the expected run
  initial begin
    #(20000 * CLK_PERIOD_NS);
    fail_count++;
    finish_test();
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clock);
    @(negedge clock);
    check(bridge_enable, 1'b0);
    @(posedge clock);
    srst <= 1'b0;
    settle();
    check(bridge_enable, 1'b1);
    check(fullstep_pin_oe, 1'b1);
    reg_rd(ADDR_CTRL, rd);
    check(rd, CTRL_RESET);
    reg_rd(4'hc, rd);
    check(rd, 32'h0000_0000);
    reg_wr(ADDR_POSITION, 32'h0001_1234);
    check_pos();
    $display("test reset done");
    for (int s = 15; s >= 0; s--) begin
      do_step(1'b1, 4'(s));
      check_pos();
      check(fullstep_pin_oe, pos % 32000 == 0);
      check(fullstep_line, pos % 32000 != 0);
    end
    reg_rd(ADDR_STATUS, rd);
    check(rd[ST_INVALID], 1'b1);
    $display("test resolution done");
    ctl.levels(1'b1, 1'b0);
    settle();
    pos = 0;
    check(bridge_enable, 1'b0);
    check(phase_a_amp, 8'h00);
    check(phase_b_amp >= 8'hf0, 1'b1);
    check({phase_a_neg, phase_b_neg}, 2'b00);
    check_pos();
    ctl.levels(1'b1, 1'b1);
    settle();
    check(bridge_enable, 1'b1);
    do_step(1'b0, 4'hf);
    check_pos();
    check(phase_a_neg, 1'b1);
    check(phase_b_neg, 1'b0);
    ctl.set_lines(1'b1, 4'hc);
    settle();
    reg_rd(ADDR_STATUS, rd);
    check(rd[ST_DIR], 1'b0);
    check(rd[ST_RES_LSB+:4], 4'hf);
    check_pos();
    do_step(1'b1, 4'hc);
    check_pos();
    $display("test reset and held lines done");
    ctl.levels(1'b0, 1'b1);
    settle();
    check(bridge_enable, 1'b0);
    do_step(1'b1, 4'hf);
    do_step(1'b1, 4'hf);
    check_pos();
    ctl.levels(1'b1, 1'b1);
    settle();
    check(bridge_enable, 1'b1);
    $display("test enable done");
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      cause[i] <= 1'b1;
      settle();
      check(fault_pin_oe, 1'b1);
      check(fault_line, 1'b0);
      ctl.levels(1'b1, 1'b0);
      ctl.levels(1'b1, 1'b1);
      settle();
      check(fault_pin_oe, 1'b1);
      check(bridge_enable, 1'b0);
      @(posedge clock);
      cause[i] <= 1'b0;
      settle();
      check(fault_pin_oe, 1'b1);
      ctl.levels(1'b1, 1'b0);
      ctl.levels(1'b1, 1'b1);
      settle();
      check(fault_pin_oe, 1'b0);
      check(bridge_enable, 1'b1);
    end
    $display("test fault done");
    @(posedge clock);
    over_temperature <= 1'b1;
    settle();
    check(bridge_enable, 1'b0);
    check(fault_pin_oe, 1'b0);
    @(posedge clock);
    over_temperature <= 1'b0;
    settle();
    check(bridge_enable, 1'b1);
    $display("test over-temperature done");
    reg_wr(ADDR_CTRL, 32'h0000_0000);
    settle();
    check(bridge_enable, 1'b0);
    reg_wr(ADDR_CTRL, CTRL_RESET);
    settle();
    check(bridge_enable, 1'b1);
    $display("test run bit done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
